// [hdl/sfc_flash_ctrl.sv]
// serial flash operation control: framing, command groups, protection, busy
`timescale 1ns/1ps
module sfc_flash_ctrl #(
    parameter int FIFO_DEPTH = sfc_pkg::FIFO_DEPTH
) (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic        sck,
    input  wire logic        cs_n,
    input  wire logic        si,
    input  wire logic        wp_n,
    input  wire logic        hw_reset_n,
    input  wire logic        op_done,
    input  wire logic [7:0]  rd_data,
    input  wire logic        buf_wr_ready,
    output logic             so_o,
    output logic             so_oe,
    output logic             rdy_busy_o,
    output logic             rdy_busy_oe,
    output logic             busy,
    output logic             op_launch,
    output logic [7:0]       launch_op,
    output logic [23:0]      launch_addr,
    output logic             rd_req,
    output logic [1:0]       rd_sel,
    output logic [7:0]       buf_wr_data,
    output logic             buf_wr_buf2,
    output logic             buf_wr_valid,
    output logic             overrun,
    output logic             cmd_reject,
    output logic             prot_active,
    output logic [7:0]       prot_sectors,
    output logic             mode3
);
    localparam logic [2:0] HDR = sfc_pkg::HDR_BYTES;

    if (FIFO_DEPTH < 2) begin : g_chk
        $error("fifo depth too small");
    end

    // pin synchronisers
    logic [4:0] pin_s;
    sfc_sync #(.W(5), .INIT(5'h1B)) u_sync (
        .mclk  (mclk),
        .rst_n (rst_n),
        .ce    (ce),
        .d     ({hw_reset_n, wp_n, si, cs_n, sck}),
        .q     (pin_s)
    );

    wire sck_s  = pin_s[0];
    wire cs_s   = pin_s[1];
    wire si_s   = pin_s[2];
    wire wp_s   = pin_s[3];
    wire rpin_s = pin_s[4];
    wire ires   = !rst_n || !rpin_s;

    logic        sck_reg;
    logic        cs_reg;
    logic        sel_reg;
    logic [2:0]  bit_reg;
    logic [7:0]  sh_reg;
    logic [2:0]  byte_reg;
    logic [7:0]  op_reg;
    logic [23:0] addr_reg;
    logic        acc_reg;
    logic [7:0]  out_reg;
    logic [2:0]  obit_reg;
    logic        rd_act_reg;
    logic        ld_reg;
    logic        sw_prot_reg;
    logic        bbuf_reg;
    logic        bbuf2_reg;
    logic        wv_reg;
    logic [8:0]  wd_reg;

    // edge detection on the synchronised pins
    wire sck_rise = sck_s && !sck_reg;
    wire sck_fall = !sck_s && sck_reg;
    wire cs_fall  = cs_reg && !cs_s;
    wire cs_rise  = !cs_reg && cs_s;

    // byte assembly
    wire [7:0] byte_in   = {sh_reg[6:0], si_s};
    wire       byte_done = sel_reg && sck_rise && bit_reg == 3'd7;
    wire       op_take   = byte_done && byte_reg == 3'd0;
    wire       hdr_done  = byte_done && byte_reg == HDR - 3'd1;
    wire       pay       = byte_done && byte_reg == HDR;
    wire [2:0] byte_next = (byte_reg == HDR) ? HDR : byte_reg + 3'd1;

    // command decode
    sfc_pkg::sfc_cls_t cls;
    sfc_pkg::sfc_cls_t ncls;
    assign cls  = sfc_pkg::sfc_op_class(op_reg);
    assign ncls = sfc_pkg::sfc_op_class(byte_in);

    wire cur_b2   = sfc_pkg::sfc_op_buf2(op_reg);
    wire new_b2   = sfc_pkg::sfc_op_buf2(byte_in);
    wire new_arr  = ncls inside {sfc_pkg::CL_ARR_RD, sfc_pkg::CL_PROG,
                                 sfc_pkg::CL_XFER, sfc_pkg::CL_ERASE, sfc_pkg::CL_SPR};
    wire new_buf  = ncls inside {sfc_pkg::CL_BUF_RD, sfc_pkg::CL_BUF_WR};
    wire buf_hit  = bbuf_reg && new_b2 == bbuf2_reg;
    wire arr_ref  = busy && new_arr;
    wire buf_ref  = busy && new_buf && buf_hit;
    wire new_ok   = !arr_ref && !buf_ref && ncls != sfc_pkg::CL_NONE;

    wire cur_mem  = cls inside {sfc_pkg::CL_ARR_RD, sfc_pkg::CL_BUF_RD};
    wire cur_loc  = cls inside {sfc_pkg::CL_STAT, sfc_pkg::CL_ID};
    wire self_tm  = cls inside {sfc_pkg::CL_PROG, sfc_pkg::CL_XFER, sfc_pkg::CL_ERASE};

    // read data path
    wire out_next = sel_reg && rd_act_reg && sck_fall && obit_reg == 3'd7;
    wire first_m  = hdr_done && acc_reg && cur_mem;
    wire first_l  = op_take && new_ok && ncls inside {sfc_pkg::CL_STAT, sfc_pkg::CL_ID};
    wire fetch    = first_m || (out_next && cur_mem);
    wire [7:0] st_byte = 8'(({7'h00, !busy} << sfc_pkg::ST_RDY_BIT)
                          | ({7'h00, prot_active} << sfc_pkg::ST_PROT_BIT));
    wire [7:0] loc_byte = (cls == sfc_pkg::CL_ID) ? sfc_pkg::ID_CODE : st_byte;

    // buffer write, launch and protection command terms
    wire wr_take = pay && acc_reg && cls == sfc_pkg::CL_BUF_WR;
    wire spr_tk  = pay && acc_reg && cls == sfc_pkg::CL_SPR;
    wire go      = cs_rise && sel_reg && acc_reg && self_tm && byte_reg == HDR && !busy;
    wire pen_tk  = cs_rise && sel_reg && acc_reg && cls == sfc_pkg::CL_PEN;
    wire pdis_tk = cs_rise && sel_reg && acc_reg && cls == sfc_pkg::CL_PDIS;

    sfc_stream_if #(.W(sfc_pkg::FIFO_W)) wr_s ();
    assign wr_s.valid = wv_reg;
    assign wr_s.data  = wd_reg;

    sfc_fifo #(.W(sfc_pkg::FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .mclk      (mclk),
        .rst_n     (!ires),
        .ce        (ce),
        .in_s      (wr_s),
        .out_data  ({buf_wr_buf2, buf_wr_data}),
        .out_valid (buf_wr_valid),
        .out_ready (buf_wr_ready)
    );

    // frame and shift state
    always_ff @(posedge mclk) begin
        if (ce) begin
            if (ires) begin
                sck_reg  <= 1'b1;
                cs_reg   <= 1'b1;
                sel_reg  <= 1'b0;
                bit_reg  <= 3'd0;
                sh_reg   <= 8'h00;
                byte_reg <= 3'd0;
                op_reg   <= 8'h00;
                addr_reg <= 24'h000000;
                acc_reg  <= 1'b0;
                mode3    <= sfc_pkg::MODE_RST;
            end else begin
                sck_reg <= sck_s;
                cs_reg  <= cs_s;
                if (cs_fall) begin
                    sel_reg  <= 1'b1;
                    bit_reg  <= 3'd0;
                    byte_reg <= 3'd0;
                    acc_reg  <= 1'b0;
                    mode3    <= sck_s;
                end else if (cs_rise) begin
                    sel_reg <= 1'b0;
                end else if (sel_reg && sck_rise) begin
                    sh_reg  <= byte_in;
                    bit_reg <= bit_reg + 3'd1;
                end
                if (byte_done) begin
                    byte_reg <= byte_next;
                end
                if (op_take) begin
                    op_reg  <= byte_in;
                    acc_reg <= new_ok;
                end
                if (byte_done && byte_reg != 3'd0 && byte_reg != HDR) begin
                    addr_reg <= {addr_reg[15:0], byte_in};
                end
            end
        end
    end

    // serial output
    always_ff @(posedge mclk) begin
        if (ce) begin
            if (ires) begin
                so_o       <= 1'b0;
                so_oe      <= 1'b0;
                out_reg    <= 8'h00;
                obit_reg   <= 3'd0;
                rd_act_reg <= 1'b0;
                ld_reg     <= 1'b0;
                rd_req     <= 1'b0;
                rd_sel     <= 2'b00;
            end else begin
                rd_req <= fetch && sel_reg;
                ld_reg <= (fetch || first_l || (out_next && cur_loc)) && sel_reg;
                if (fetch) begin
                    rd_sel <= {cls == sfc_pkg::CL_BUF_RD && cur_b2,
                               cls == sfc_pkg::CL_BUF_RD && !cur_b2};
                end
                if (!sel_reg || cs_rise) begin
                    so_oe      <= 1'b0;
                    rd_act_reg <= 1'b0;
                    obit_reg   <= 3'd0;
                end else if (ld_reg) begin
                    out_reg    <= cur_mem ? rd_data : loc_byte;
                    rd_act_reg <= 1'b1;
                end else if (rd_act_reg && sck_fall) begin
                    so_o     <= out_reg[7];
                    so_oe    <= 1'b1;
                    out_reg  <= {out_reg[6:0], 1'b0};
                    obit_reg <= obit_reg + 3'd1;
                end
            end
        end
    end

    // busy, launch, protection and buffer writes
    always_ff @(posedge mclk) begin
        if (ce) begin
            if (ires) begin
                busy        <= 1'b0;
                rdy_busy_o  <= 1'b0;
                rdy_busy_oe <= 1'b0;
                op_launch   <= 1'b0;
                launch_op   <= 8'h00;
                launch_addr <= 24'h000000;
                bbuf_reg    <= 1'b0;
                bbuf2_reg   <= 1'b0;
                sw_prot_reg <= 1'b0;
                prot_active <= 1'b0;
                cmd_reject  <= 1'b0;
                wv_reg      <= 1'b0;
                wd_reg      <= 9'h000;
                overrun     <= 1'b0;
            end else begin
                op_launch  <= go;
                cmd_reject <= op_take && !new_ok;
                wv_reg     <= wr_take && wr_s.ready;
                overrun    <= wr_take && !wr_s.ready;
                if (wr_take) begin
                    wd_reg <= {cur_b2, byte_in};
                end
                if (go) begin
                    busy        <= 1'b1;
                    rdy_busy_oe <= 1'b1;
                    launch_op   <= op_reg;
                    launch_addr <= addr_reg;
                    bbuf_reg    <= cls != sfc_pkg::CL_ERASE;
                    bbuf2_reg   <= cur_b2;
                end else if (op_done) begin
                    busy        <= 1'b0;
                    rdy_busy_oe <= 1'b0;
                    bbuf_reg    <= 1'b0;
                end
                if (pen_tk) begin
                    sw_prot_reg <= 1'b1;
                end else if (pdis_tk && wp_s) begin
                    sw_prot_reg <= 1'b0;
                end
                prot_active <= sw_prot_reg || !wp_s;
            end
        end
    end

    // sector protection register survives the reset pin
    always_ff @(posedge mclk) begin
        if (ce) begin
            if (!rst_n) begin
                prot_sectors <= sfc_pkg::SECT_RST;
            end else if (spr_tk) begin
                prot_sectors <= byte_in;
            end
        end
    end

    property p_launch_busy;
        @(posedge mclk) disable iff (!rst_n)
        op_launch |-> busy && rdy_busy_oe && !$past(busy);
    endproperty
    a_launch_busy: assert property (p_launch_busy) else $error("launch without busy");

    property p_done_release;
        @(posedge mclk) disable iff (ires)
        ce && op_done && !go |=> !busy && !rdy_busy_oe;
    endproperty
    a_done_release: assert property (p_done_release) else $error("busy stuck");

    property p_hiz;
        @(posedge mclk) disable iff (!rst_n)
        !sel_reg |-> !so_oe;
    endproperty
    a_hiz: assert property (p_hiz) else $error("output driven unselected");

    property p_mode;
        @(posedge mclk) disable iff (ires)
        ce && cs_fall |=> mode3 == $past(sck_s);
    endproperty
    a_mode: assert property (p_mode) else $error("clock mode wrong");

    property p_pin_prot;
        @(posedge mclk) disable iff (ires)
        ce && !wp_s |=> prot_active;
    endproperty
    a_pin_prot: assert property (p_pin_prot) else $error("pin did not protect");

    property p_dis_ignored;
        @(posedge mclk) disable iff (ires)
        ce && pdis_tk && !wp_s && sw_prot_reg |=> sw_prot_reg ##1 prot_active;
    endproperty
    a_dis_ignored: assert property (p_dis_ignored) else $error("disable not ignored");

    property p_arr_refuse;
        @(posedge mclk) disable iff (ires)
        ce && op_take && busy && ncls == sfc_pkg::CL_ARR_RD |=> cmd_reject && !acc_reg;
    endproperty
    a_arr_refuse: assert property (p_arr_refuse) else $error("array read while busy");

    property p_buf_free;
        @(posedge mclk) disable iff (ires)
        ce && op_take && new_buf && !buf_hit && ncls != sfc_pkg::CL_NONE |=> acc_reg;
    endproperty
    a_buf_free: assert property (p_buf_free) else $error("free buffer refused");

    property p_reset;
        @(posedge mclk) disable iff (!rst_n)
        ce && !rpin_s |=> mode3 && !busy && !so_oe && !sel_reg;
    endproperty
    a_reset: assert property (p_reset) else $error("reset did not idle");
endmodule : sfc_flash_ctrl

// [hdl/sfc_pkg.sv]
// constants, command classes and decode helpers for the serial flash control
package sfc_pkg;

    typedef enum logic [3:0] {
        CL_NONE, CL_ARR_RD, CL_BUF_RD, CL_BUF_WR, CL_STAT, CL_ID,
        CL_PROG, CL_XFER, CL_ERASE, CL_PEN, CL_PDIS, CL_SPR
    } sfc_cls_t;

    localparam logic [2:0] HDR_BYTES   = 3'd4;
    localparam logic [7:0] SECT_RST    = 8'h00;
    localparam logic       MODE_RST    = 1'b1;
    localparam int         ST_RDY_BIT  = 7;
    localparam int         ST_PROT_BIT = 6;
    localparam int         FIFO_DEPTH  = 32;
    localparam int         FIFO_W      = 9;
    // arbitrary value
    localparam logic [7:0] ID_CODE     = 8'h5A;
    localparam logic [7:0] OP_PEN      = 8'hA1;
    localparam logic [7:0] OP_PDIS     = 8'hA2;
    localparam logic [7:0] OP_SPR      = 8'hA3;

    function automatic sfc_cls_t sfc_op_class(input logic [7:0] op);
        case (op)
            8'hD2, 8'h52, 8'hE8, 8'h68:                      return CL_ARR_RD;
            8'hD4, 8'h54, 8'hD6, 8'h56:                      return CL_BUF_RD;
            8'h84, 8'h87:                                    return CL_BUF_WR;
            8'hD7, 8'h57:                                    return CL_STAT;
            8'h9F:                                           return CL_ID;
            8'h83, 8'h86, 8'h88, 8'h89, 8'h82, 8'h85, 8'h58, 8'h59: return CL_PROG;
            8'h53, 8'h55, 8'h60, 8'h61:                      return CL_XFER;
            8'h81, 8'h50:                                    return CL_ERASE;
            OP_PEN:                                          return CL_PEN;
            OP_PDIS:                                         return CL_PDIS;
            OP_SPR:                                          return CL_SPR;
            default:                                         return CL_NONE;
        endcase
    endfunction : sfc_op_class

    function automatic logic sfc_op_buf2(input logic [7:0] op);
        return op inside {8'h87, 8'h86, 8'h89, 8'h85, 8'h59, 8'h55, 8'h61, 8'hD6, 8'h56};
    endfunction : sfc_op_buf2

endpackage : sfc_pkg

// [hdl/sfc_stream_if.sv]
// valid/ready byte stream between the serial front end and the fifo
`timescale 1ns/1ps
interface sfc_stream_if #(parameter int W = 9);
    logic [W-1:0] data;
    logic         valid;
    logic         ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface : sfc_stream_if

// [hdl/sfc_sync.sv]
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sfc_sync #(
    parameter int           W    = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input  wire logic         mclk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge mclk) begin
        if (ce) begin
            if (!rst_n) begin
                meta_reg <= INIT;
                q        <= INIT;
            end else begin
                meta_reg <= d;
                q        <= meta_reg;
            end
        end
    end
endmodule : sfc_sync

// [hdl/sfc_fifo.sv]
// buffer-write byte fifo with registered read data
`timescale 1ns/1ps
module sfc_fifo #(
    parameter int W     = 9,
    parameter int DEPTH = 32
) (
    input  wire logic         mclk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    sfc_stream_if.snk         in_s,
    output logic      [W-1:0] out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
        $error("fifo depth must be a power of two, at least 2");
    end

    logic [W-1:0] mem [DEPTH];
    logic [AW:0]  wp_reg;
    logic [AW:0]  rp_reg;

    wire [AW:0] fill  = wp_reg - rp_reg;
    wire        full  = fill == (AW+1)'(DEPTH);
    wire        empty = wp_reg == rp_reg;
    wire        push  = in_s.valid && !full;
    wire        pop   = !empty && (!out_valid || out_ready);

    assign in_s.ready = !full;

    always_ff @(posedge mclk) begin
        if (ce && push) begin
            mem[wp_reg[AW-1:0]] <= in_s.data;
        end
    end

    always_ff @(posedge mclk) begin
        if (ce) begin
            if (!rst_n) begin
                wp_reg    <= '0;
                rp_reg    <= '0;
                out_data  <= '0;
                out_valid <= 1'b0;
            end else begin
                if (push) begin
                    wp_reg <= wp_reg + 1'b1;
                end
                if (pop) begin
                    out_data  <= mem[rp_reg[AW-1:0]];
                    rp_reg    <= rp_reg + 1'b1;
                    out_valid <= 1'b1;
                end else if (out_ready) begin
                    out_valid <= 1'b0;
                end
            end
        end
    end
endmodule : sfc_fifo

// [verification/sfc_host_model.sv]
// host serial controller model driving the flash control pins
`timescale 1ns/1ps
module sfc_host_model (
    input  wire logic so_o,
    input  wire logic so_oe,
    output logic      sck,
    output logic      cs_n,
    output logic      si,
    output logic      wp_n,
    output logic      hw_reset_n
);
    logic idle_lvl;
    initial begin
        sck        = 1'b1;
        cs_n       = 1'b1;
        si         = 1'b0;
        wp_n       = 1'b1;
        hw_reset_n = 1'b1;
        idle_lvl   = 1'b1;
    end
    task automatic start(input logic lvl);
        sck      = lvl;
        idle_lvl = lvl;
        #230;
        cs_n = 1'b0;
        #200;
    endtask : start
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sck   = 1'b0;
            si    = tx[i];
            #200;
            sck   = 1'b1;
            rx[i] = so_oe ? so_o : ~so_o;
            #200;
        end
    endtask : xfer
    task automatic stop();
        sck = idle_lvl;
        #200;
        cs_n = 1'b1;
        si   = ~si;
        #400;
    endtask : stop
    task automatic set_pins(input logic wp, input logic rst);
        #7;
        wp_n       = wp;
        hw_reset_n = rst;
        #400;
    endtask : set_pins
endmodule : sfc_host_model

// [verification/test_sfc_flash_ctrl.sv]
// self-checking bench of the serial flash operation control
`timescale 1ns/1ps
module test_sfc_flash_ctrl;
    logic mclk, rst_n, ce, sck, cs_n, si, wp_n, hw_reset_n, op_done, buf_wr_ready;
    logic so_o, so_oe, rdy_busy_o, rdy_busy_oe, busy, op_launch, rd_req, buf_wr_buf2;
    logic buf_wr_valid, overrun, cmd_reject, prot_active, mode3;
    logic [7:0]  rd_data, launch_op, buf_wr_data, prot_sectors, rx;
    logic [23:0] launch_addr;
    logic [1:0]  rd_sel;
    int errors, cmp_count, n_launch, n_rej, n_ovr, n_pop, r0, l0, o0, p0;

    sfc_flash_ctrl #(.FIFO_DEPTH(4)) i_dut (
        .mclk(mclk), .rst_n(rst_n), .ce(ce), .sck(sck), .cs_n(cs_n), .si(si),
        .wp_n(wp_n), .hw_reset_n(hw_reset_n), .op_done(op_done), .rd_data(rd_data),
        .buf_wr_ready(buf_wr_ready), .so_o(so_o), .so_oe(so_oe),
        .rdy_busy_o(rdy_busy_o), .rdy_busy_oe(rdy_busy_oe), .busy(busy),
        .op_launch(op_launch), .launch_op(launch_op), .launch_addr(launch_addr),
        .rd_req(rd_req), .rd_sel(rd_sel), .buf_wr_data(buf_wr_data),
        .buf_wr_buf2(buf_wr_buf2), .buf_wr_valid(buf_wr_valid), .overrun(overrun),
        .cmd_reject(cmd_reject), .prot_active(prot_active),
        .prot_sectors(prot_sectors), .mode3(mode3));
    sfc_host_model i_host (
        .so_o(so_o), .so_oe(so_oe), .sck(sck), .cs_n(cs_n), .si(si), .wp_n(wp_n),
        .hw_reset_n(hw_reset_n));

    always #25 mclk = ~mclk;
    always @(posedge mclk) begin
        n_launch += int'(op_launch === 1'b1);
        n_rej    += int'(cmd_reject === 1'b1);
        n_ovr    += int'(overrun === 1'b1);
        n_pop    += int'(buf_wr_valid === 1'b1 && buf_wr_ready === 1'b1);
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk
    task automatic stop_test();
        $display("checks %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test
    task automatic frame(input logic lvl, input int n, input logic [31:0] b, input int np);
        i_host.start(lvl);
        for (int k = 0; k < n; k++) i_host.xfer(b[31-8*k -: 8], rx);
        for (int k = 0; k < np; k++) i_host.xfer(8'hA0 + 8'(k), rx);
        i_host.stop();
    endtask : frame
    task automatic done_pulse();
        @(posedge mclk) op_done <= 1'b1;
        @(posedge mclk) op_done <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask : done_pulse

    task automatic t_reset();
        chk(mode3, 1'b1);
        chk(so_oe, 1'b0);
        chk({busy, rdy_busy_oe, rdy_busy_o}, 3'h0);
        chk(prot_sectors, 8'h00);
    endtask : t_reset
    task automatic t_mode();
        frame(1'b0, 2, 32'hD7000000, 0);
        chk(mode3, 1'b0);
        chk(rx, 8'h80);
        chk(so_oe, 1'b0);
        frame(1'b1, 2, 32'h9F000000, 0);
        chk(mode3, 1'b1);
        chk(rx, sfc_pkg::ID_CODE);
    endtask : t_mode
    task automatic t_array();
        r0 = n_rej;
        l0 = n_launch;
        frame(1'b1, 4, 32'h83123456, 0);
        chk(n_launch - l0, 1);
        chk({launch_op, launch_addr}, 32'h83123456);
        chk({busy, rdy_busy_oe}, 2'h3);
        frame(1'b1, 4, 32'hD6000000, 1);
        chk(rx, 8'hC3);
        chk(rd_sel, 2'h2);
        frame(1'b1, 2, 32'hD7000000, 0);
        chk(rx, 8'h00);
        @(posedge mclk) buf_wr_ready <= 1'b0;
        o0 = n_ovr;
        p0 = n_pop;
        frame(1'b1, 4, 32'h87000000, 8);
        chk(n_rej - r0, 0);
        chk(n_ovr != o0, 1'b1);
        chk({buf_wr_valid, buf_wr_buf2, buf_wr_data}, 10'h3A0);
        @(posedge mclk) buf_wr_ready <= 1'b1;
        for (int k = 0; k < 60 && buf_wr_valid !== 1'b0; k++) @(posedge mclk);
        chk(buf_wr_valid, 1'b0);
        chk(n_pop - p0 + n_ovr - o0, 8);
        frame(1'b1, 4, 32'h84000000, 1);
        chk(n_rej - r0, 1);
        frame(1'b1, 4, 32'hD2000000, 1);
        chk(n_rej - r0, 2);
        frame(1'b1, 4, 32'h86000000, 0);
        chk(n_rej - r0, 3);
        chk(n_launch - l0, 1);
        done_pulse();
        chk({busy, rdy_busy_oe}, 2'h0);
        frame(1'b1, 2, 32'hD7000000, 0);
        chk(rx, 8'h80);
    endtask : t_array
    task automatic t_erase();
        r0 = n_rej;
        frame(1'b1, 4, 32'h81000400, 0);
        chk(busy, 1'b1);
        @(posedge mclk) ce <= 1'b0;
        done_pulse();
        chk(busy, 1'b1);
        @(posedge mclk) ce <= 1'b1;
        frame(1'b1, 4, 32'h84000000, 1);
        frame(1'b1, 4, 32'h87000000, 1);
        chk(n_rej - r0, 0);
        done_pulse();
        chk(busy, 1'b0);
    endtask : t_erase
    task automatic t_protect();
        frame(1'b1, 1, {sfc_pkg::OP_PEN, 24'h0}, 0);
        chk(prot_active, 1'b1);
        i_host.set_pins(1'b0, 1'b1);
        frame(1'b1, 1, {sfc_pkg::OP_PDIS, 24'h0}, 0);
        i_host.set_pins(1'b1, 1'b1);
        chk(prot_active, 1'b1);
        frame(1'b1, 1, {sfc_pkg::OP_PDIS, 24'h0}, 0);
        chk(prot_active, 1'b0);
        i_host.set_pins(1'b0, 1'b1);
        chk(prot_active, 1'b1);
        i_host.set_pins(1'b1, 1'b1);
        chk(prot_active, 1'b0);
        frame(1'b1, 4, {sfc_pkg::OP_SPR, 24'h0}, 1);
        chk(prot_sectors, 8'hA0);
    endtask : t_protect
    task automatic t_hw_reset();
        frame(1'b0, 4, 32'h50001000, 0);
        chk({busy, mode3}, 2'h2);
        i_host.set_pins(1'b1, 1'b0);
        chk({busy, rdy_busy_oe, so_oe}, 3'h0);
        chk(mode3, 1'b1);
        i_host.set_pins(1'b1, 1'b1);
        frame(1'b1, 2, 32'hD7000000, 0);
        chk(rx, 8'h80);
    endtask : t_hw_reset

    initial begin
        mclk         = 1'b0;
        rst_n        = 1'b0;
        ce           = 1'b1;
        op_done      = 1'b0;
        rd_data      = 8'hC3;
        buf_wr_ready = 1'b1;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        t_reset();
        t_mode();
        t_array();
        t_erase();
        t_protect();
        t_hw_reset();
        stop_test();
    end
    initial begin
        #2_000_000;
        errors++;
        stop_test();
    end
endmodule : test_sfc_flash_ctrl
